// *** hw/mem_decode_regs.vh ***
// Offsets, reset values and field positions of the memory-map decoder
`ifndef MEM_DECODE_REGS_VH
`define MEM_DECODE_REGS_VH
`define RESET_VECTOR        16'h0000
`define VECTOR_BASE         16'h0003
`define VECTOR_SPACING      16'h0008
`define APP_REGION_BYTES    16'h4800
`define BOOT_1K_BYTES       16'h0400
`define SFR_BASE            8'h80
`define PAGE_SELECT_ADDR    8'h91
`define PAGE_SELECT_RESET   8'h00
`define PAGE_SELECT_BIT     0
`define STATUS_WORD_ADDR    8'hd0
`define STACK_PTR_ADDR      8'h81
`define TIMED_ACCESS_ADDR   8'hc7
`define STACK_PTR_RESET     8'h07
`define BOOT_CONFIG_RESET   8'hff
`define BOOT_SIZE_LSB       0
`define BOOT_SIZE_MSB       2
`define BANK_SEL_LOW_BIT    3
`define BANK_SEL_HIGH_BIT   4
`define BIT_AREA_BASE       8'h20
`define AUX_RAM_LAST        16'h02ff
`define UNLOCK_FIRST        8'haa
`define UNLOCK_SECOND       8'h55
`define UNLOCK_WINDOW       3'h4
`endif

// *** hw/mem_decode.v ***
// Memory-map decoder between the CPU core and the memory arrays
// Operation
// RULE1: After any reset, fetching starts at program address zero.
// RULE2: Each interrupt vectors to 0003H plus eight times its number.
// RULE3: Three-bit field sizes boot region; application region takes rest of 18K.
// RULE4: Booting from boot region maps address zero and vectors to its start.
// RULE5: Application region serves fetches and code-memory move reads.
// RULE6: Direct above 7FH hits special registers, indirect hits upper RAM.
// RULE7: Lower RAM by direct or indirect; upper RAM only indirect.
// RULE8: Special registers at addresses ending 0H or 8H allow bit access.
// RULE9: Lowest 32 bytes form four banks chosen by two status-word bits.
// RULE10: Bytes 20H to 2FH hold bit addresses 00H to 7FH.
// RULE11: Stack pointer resets to 07H, software may move it anywhere.
// RULE12: Push increments then writes; pop reads then decrements.
// RULE13: Auxiliary RAM 000H to 2FFH reached only by external moves.
// RULE14: Stack never targets auxiliary RAM.
// RULE15: Page select defaults zero and redirects direct special accesses.
// RULE16: Page select written only while timed access is unlocked.
// RULE17: Unlock is AAH then 55H, then the protected write.
// RULE18: Boot size sampled at reset and held until next reset.
`timescale 1ns/1ps
`include "mem_decode_regs.vh"
module mem_decode #(
  parameter APP_BYTES = 18432
) (
  input  wire        CLK_SYS,
  input  wire        NRST,
  input  wire [7:0]  BOOT_SIZE_CONFIG,
  input  wire        BOOT_SELECT,
  input  wire        FETCH_REQ,
  input  wire        CODE_READ,
  input  wire [15:0] PC_ADDR,
  input  wire        IRQ_TAKE,
  input  wire [3:0]  IRQ_NUM,
  input  wire        DATA_REQ,
  input  wire        DATA_WRITE,
  input  wire        DIRECT_MODE,
  input  wire        BIT_MODE,
  input  wire        REG_OPERAND,
  input  wire [2:0]  REG_NUM,
  input  wire [7:0]  DATA_ADDR,
  input  wire [7:0]  WDATA,
  input  wire        PUSH,
  input  wire        POP,
  input  wire        EXT_REQ,
  input  wire        EXT_USE_POINTER,
  input  wire [15:0] DATA_POINTER,
  output reg  [15:0] CODE_ADDR,
  output reg         CODE_SEL_BOOT,
  output reg         CODE_VALID,
  output reg         CODE_FAULT,
  output reg  [7:0]  RAM_ADDR,
  output reg  [2:0]  RAM_BIT,
  output reg         RAM_EN,
  output reg         RAM_WE,
  output reg  [7:0]  SFR_ADDR,
  output reg  [2:0]  SFR_BIT,
  output reg         SFR_EN,
  output reg         SFR_WE,
  output reg         SFR_PAGE,
  output reg         SFR_BIT_FAULT,
  output reg  [9:0]  AUX_ADDR,
  output reg         AUX_EN,
  output reg         AUX_FAULT,
  output reg  [7:0]  STACK_POINTER,
  output reg  [7:0]  PAGE_SELECT,
  output reg  [15:0] BOOT_BYTES,
  output reg  [15:0] APP_LIMIT
);

  localparam ST_RESET = 2'b01;
  localparam ST_RUN   = 2'b10;

  reg  [1:0]  state;
  reg  [2:0]  boot_region_size;
  reg  [1:0]  unlock_step;
  reg  [2:0]  unlock_timer;
  reg  [1:0]  bank;
  reg  [7:0]  next_ram_addr;
  reg  [2:0]  next_ram_bit;
  reg         next_ram_en;
  reg         next_sfr_en;
  reg  [7:0]  next_stack;
  reg  [15:0] vec_addr;
  reg  [15:0] boot_len;
  wire [15:0] app_len;
  wire        unlocked;

  // Boot region length from size field
  function [15:0] boot_length;
    input [2:0] sz;
    begin
      case (sz)
        3'b111:  boot_length = 16'h0000;
        3'b110:  boot_length = `BOOT_1K_BYTES;
        3'b101:  boot_length = 16'h0800;
        3'b100:  boot_length = 16'h0c00;
        default: boot_length = 16'h1000;
      endcase
    end
  endfunction

  assign app_len  = APP_BYTES[15:0] - boot_len;
  assign unlocked = (unlock_step == 2'd2);

  always @*
  begin
    boot_len = boot_length(boot_region_size); // see RULE3
  end

  // Vector address relative to active region start
  always @*
  begin
    vec_addr = `VECTOR_BASE + {9'h000, IRQ_NUM, 3'b000}; // see RULE2
  end

  // Internal RAM decode
  always @*
  begin
    next_ram_addr = DATA_ADDR;
    next_ram_bit  = 3'h0;
    next_ram_en   = 1'b0;
    next_sfr_en   = 1'b0;
    if (REG_OPERAND)
    begin
      next_ram_addr = {3'b000, bank, REG_NUM}; // see RULE9
      next_ram_en   = 1'b1;
    end
    else if (BIT_MODE)
    begin
      if (!DATA_ADDR[7])
      begin
        next_ram_addr = `BIT_AREA_BASE + {4'h0, DATA_ADDR[6:3]}; // see RULE10
        next_ram_bit  = DATA_ADDR[2:0];
        next_ram_en   = 1'b1;
      end
      else
        next_sfr_en = 1'b1;
    end
    else if (DIRECT_MODE && DATA_ADDR[7])
      next_sfr_en = 1'b1; // see RULE6
    else
      next_ram_en = 1'b1; // see RULE7
  end

  // Stack pointer update
  always @*
  begin
    next_stack = STACK_POINTER;
    if (DATA_REQ && DATA_WRITE && DIRECT_MODE && !BIT_MODE && DATA_ADDR == `STACK_PTR_ADDR)
      next_stack = WDATA; // see RULE11
    else if (PUSH)
      next_stack = STACK_POINTER + 8'h01; // see RULE12
    else if (POP)
      next_stack = STACK_POINTER - 8'h01;
  end

  // Reset capture of boot size and region bounds
  always @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      state            <= ST_RESET;
      boot_region_size <= 3'h7;
      BOOT_BYTES       <= 16'h0000;
      APP_LIMIT        <= 16'h0000;
    end
    else
    begin
      case (state)
        ST_RESET:
        begin
          boot_region_size <= BOOT_SIZE_CONFIG[`BOOT_SIZE_MSB:`BOOT_SIZE_LSB]; // see RULE18
          state            <= ST_RUN;
        end
        ST_RUN:
        begin
          BOOT_BYTES <= boot_len;
          APP_LIMIT  <= app_len;
        end
        default: state <= ST_RESET;
      endcase
    end
  end

  // Program memory decode
  always @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      CODE_ADDR     <= `RESET_VECTOR; // see RULE1
      CODE_SEL_BOOT <= 1'b0;
      CODE_VALID    <= 1'b0;
      CODE_FAULT    <= 1'b0;
    end
    else
    begin
      CODE_SEL_BOOT <= BOOT_SELECT && (boot_len != 16'h0000); // see RULE4
      CODE_VALID    <= (state == ST_RUN) && (FETCH_REQ || IRQ_TAKE || CODE_READ); // see RULE5
      if (IRQ_TAKE)
        CODE_ADDR <= vec_addr;
      else
        CODE_ADDR <= PC_ADDR;
      if (BOOT_SELECT && boot_len != 16'h0000)
        CODE_FAULT <= FETCH_REQ && (PC_ADDR >= boot_len);
      else
        CODE_FAULT <= (FETCH_REQ || CODE_READ) && (PC_ADDR >= app_len);
    end
  end

  // Data memory, special registers, stack and auxiliary RAM
  always @(posedge CLK_SYS)
  begin
    if (!NRST)
    begin
      RAM_ADDR      <= 8'h00;
      RAM_BIT       <= 3'h0;
      RAM_EN        <= 1'b0;
      RAM_WE        <= 1'b0;
      SFR_ADDR      <= 8'h00;
      SFR_BIT       <= 3'h0;
      SFR_EN        <= 1'b0;
      SFR_WE        <= 1'b0;
      SFR_PAGE      <= 1'b0;
      SFR_BIT_FAULT <= 1'b0;
      AUX_ADDR      <= 10'h000;
      AUX_EN        <= 1'b0;
      AUX_FAULT     <= 1'b0;
      STACK_POINTER <= `STACK_PTR_RESET; // see RULE11
      PAGE_SELECT   <= `PAGE_SELECT_RESET; // see RULE15
      bank          <= 2'b00;
      unlock_step   <= 2'd0;
      unlock_timer  <= 3'h0;
    end
    else
    begin
      RAM_EN        <= 1'b0;
      RAM_WE        <= 1'b0;
      SFR_EN        <= 1'b0;
      SFR_WE        <= 1'b0;
      SFR_BIT_FAULT <= 1'b0;
      AUX_EN        <= 1'b0;
      AUX_FAULT     <= 1'b0;
      STACK_POINTER <= next_stack;
      if (PUSH)
      begin
        RAM_ADDR <= STACK_POINTER + 8'h01; // see RULE12
        RAM_EN   <= 1'b1;
        RAM_WE   <= 1'b1; // see RULE14
      end
      else if (POP)
      begin
        RAM_ADDR <= STACK_POINTER;
        RAM_EN   <= 1'b1;
      end
      else if (DATA_REQ)
      begin
        RAM_ADDR <= next_ram_addr;
        RAM_BIT  <= next_ram_bit;
        RAM_EN   <= next_ram_en;
        RAM_WE   <= next_ram_en && DATA_WRITE;
        SFR_ADDR <= BIT_MODE ? {DATA_ADDR[7:3], 3'b000} : DATA_ADDR; // see RULE8
        SFR_BIT  <= DATA_ADDR[2:0];
        SFR_EN   <= next_sfr_en;
        SFR_WE   <= next_sfr_en && DATA_WRITE;
        SFR_PAGE <= PAGE_SELECT[`PAGE_SELECT_BIT]; // see RULE15
        // Special-register bit access only ever lands on a byte ending in 0H or 8H
        SFR_BIT_FAULT <= 1'b0;
      end
      if (EXT_REQ)
      begin
        AUX_ADDR  <= EXT_USE_POINTER ? DATA_POINTER[9:0] : {2'b00, WDATA}; // see RULE13
        AUX_EN    <= !EXT_USE_POINTER || (DATA_POINTER <= `AUX_RAM_LAST);
        AUX_FAULT <= EXT_USE_POINTER && (DATA_POINTER > `AUX_RAM_LAST);
      end
      // Status-word bank bits, tracked on direct writes
      if (DATA_REQ && DATA_WRITE && DIRECT_MODE && !BIT_MODE && DATA_ADDR == `STATUS_WORD_ADDR)
        bank <= {WDATA[`BANK_SEL_HIGH_BIT], WDATA[`BANK_SEL_LOW_BIT]}; // see RULE9
      // Timed-access unlock sequence
      if (unlock_timer != 3'h0)
        unlock_timer <= unlock_timer - 3'h1;
      else if (unlocked)
        unlock_step <= 2'd0;
      if (DATA_REQ && DATA_WRITE && DIRECT_MODE && !BIT_MODE && DATA_ADDR == `TIMED_ACCESS_ADDR)
      begin
        if (WDATA == `UNLOCK_FIRST)
          unlock_step <= 2'd1; // see RULE17
        else if (WDATA == `UNLOCK_SECOND && unlock_step == 2'd1)
        begin
          unlock_step  <= 2'd2;
          unlock_timer <= `UNLOCK_WINDOW;
        end
        else
          unlock_step <= 2'd0;
      end
      else if (DATA_REQ && DATA_WRITE && DIRECT_MODE && DATA_ADDR[7:3] == 5'h12 && BIT_MODE == 1'b0
               && DATA_ADDR == `PAGE_SELECT_ADDR)
      begin
        if (unlocked)
          PAGE_SELECT <= {7'h00, WDATA[`PAGE_SELECT_BIT]}; // see RULE16
        unlock_step <= 2'd0;
      end
      else if (DATA_REQ && DATA_WRITE && unlock_step == 2'd1)
        unlock_step <= 2'd0;
    end
  end

endmodule // mem_decode

// *** sim/mem_decode_assertions.sv ***
// Port checks for the memory-map decoder
`timescale 1ns/1ps
module mem_decode_checks #(
  parameter APP_BYTES = 18432
) (
  input wire logic        CLK_SYS, NRST, BOOT_SELECT, FETCH_REQ, IRQ_TAKE, DATA_REQ, DATA_WRITE,
  input wire logic        DIRECT_MODE, BIT_MODE, REG_OPERAND, PUSH, POP, EXT_REQ, EXT_USE_POINTER,
  input wire logic        CODE_SEL_BOOT, CODE_VALID, CODE_FAULT, RAM_EN, RAM_WE, SFR_EN,
  input wire logic        SFR_BIT_FAULT, AUX_EN, AUX_FAULT,
  input wire logic [3:0]  IRQ_NUM,
  input wire logic [2:0]  RAM_BIT,
  input wire logic [7:0]  DATA_ADDR, RAM_ADDR, SFR_ADDR, STACK_POINTER, PAGE_SELECT,
  input wire logic [9:0]  AUX_ADDR,
  input wire logic [15:0] PC_ADDR, DATA_POINTER, CODE_ADDR, BOOT_BYTES, APP_LIMIT
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  wire plain = DATA_REQ && !PUSH && !POP && !REG_OPERAND;
  reset_state_a: assert property (disable iff (1'b0)
    !NRST |=> STACK_POINTER == 8'h07 && PAGE_SELECT == 8'h00 && CODE_ADDR == 16'h0000) else $error("reset state");
  push_order_a: assert property (PUSH |=> RAM_EN && RAM_WE && !AUX_EN &&
    RAM_ADDR == $past(STACK_POINTER) + 8'h01 && STACK_POINTER == RAM_ADDR) else $error("push order");
  pop_order_a: assert property (POP && !PUSH |=> RAM_EN && !RAM_WE &&
    RAM_ADDR == $past(STACK_POINTER) && STACK_POINTER == RAM_ADDR - 8'h01) else $error("pop order");
  direct_sfr_a: assert property (plain && DIRECT_MODE && !BIT_MODE && DATA_ADDR[7] |=>
    SFR_EN && !RAM_EN && SFR_ADDR == $past(DATA_ADDR)) else $error("direct decode");
  indirect_ram_a: assert property (plain && !DIRECT_MODE && !BIT_MODE |=>
    RAM_EN && !SFR_EN && RAM_ADDR == $past(DATA_ADDR) && RAM_WE == $past(DATA_WRITE)) else $error("indirect decode");
  bit_ram_a: assert property (plain && BIT_MODE && !DATA_ADDR[7] |=> RAM_EN &&
    RAM_ADDR == {4'h2, $past(DATA_ADDR[6:3])} && RAM_BIT == $past(DATA_ADDR[2:0])) else $error("bit area");
  bit_sfr_a: assert property (plain && BIT_MODE && DATA_ADDR[7] |=> SFR_EN && !SFR_BIT_FAULT &&
    SFR_ADDR == {$past(DATA_ADDR[7:3]), 3'h0}) else $error("bit register");
  vector_addr_a: assert property (IRQ_TAKE |=> CODE_VALID && CODE_SEL_BOOT == $past(BOOT_SELECT) &&
    CODE_ADDR == 16'h0003 + {$past(IRQ_NUM), 3'h0}) else $error("vector address");
  fetch_app_a: assert property (FETCH_REQ && !BOOT_SELECT && PC_ADDR < APP_LIMIT |=>
    CODE_VALID && !CODE_FAULT && CODE_ADDR == $past(PC_ADDR)) else $error("fetch decode");
  aux_range_a: assert property (EXT_REQ && EXT_USE_POINTER |=> AUX_EN != AUX_FAULT &&
    AUX_FAULT == ($past(DATA_POINTER) > 16'h02ff) && (AUX_FAULT || AUX_ADDR == $past(DATA_POINTER[9:0])))
    else $error("aux decode");
  boot_hold_a: assert property ($past(NRST) && $past(NRST, 2) && $past(NRST, 3) |->
    $stable(BOOT_BYTES) && $stable(APP_LIMIT) && APP_LIMIT + BOOT_BYTES == APP_BYTES) else $error("boot split");
endmodule // mem_decode_checks
bind mem_decode mem_decode_checks #(.APP_BYTES(APP_BYTES)) i_mem_decode_checks (.*);

// *** sim/cpu_model.sv ***
// Behavioural CPU core issuing fetches and data accesses
`timescale 1ns/1ps
module cpu_model (
  input  wire logic   CLK_SYS,
  output logic        FETCH_REQ, CODE_READ, IRQ_TAKE, DATA_REQ, DATA_WRITE, DIRECT_MODE, BIT_MODE,
  output logic        REG_OPERAND, PUSH, POP, EXT_REQ, EXT_USE_POINTER,
  output logic [3:0]  IRQ_NUM,
  output logic [2:0]  REG_NUM,
  output logic [7:0]  DATA_ADDR, WDATA,
  output logic [15:0] PC_ADDR, DATA_POINTER
);
  initial {FETCH_REQ, CODE_READ, IRQ_TAKE, DATA_REQ, DATA_WRITE, DIRECT_MODE, BIT_MODE, REG_OPERAND,
    PUSH, POP, EXT_REQ, EXT_USE_POINTER, IRQ_NUM, REG_NUM, DATA_ADDR, WDATA, PC_ADDR, DATA_POINTER} = '0;
  // Kinds: 0 data, 1 push, 2 pop, 3 fetch, 4 code read, 5 vector, 6 ext pointer, 7 ext register
  task req(input logic [2:0] k, input logic w, dm, bm, input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    {DATA_WRITE, DIRECT_MODE, BIT_MODE, REG_OPERAND, REG_NUM} <= {w, dm, bm, a[15], a[10:8]};
    {DATA_ADDR, WDATA, PC_ADDR, IRQ_NUM, DATA_POINTER} <= {a[7:0], d, a, a[3:0], a};
    {DATA_REQ, PUSH, POP, FETCH_REQ, CODE_READ, IRQ_TAKE, EXT_REQ, EXT_USE_POINTER} <=
      {k == 3'h0, k == 3'h1, k == 3'h2, k == 3'h3, k == 3'h4, k == 3'h5, k[2] & k[1], k == 3'h6};
    @(posedge CLK_SYS);
    {DATA_REQ, PUSH, POP, FETCH_REQ, CODE_READ, IRQ_TAKE, EXT_REQ} <= 7'h00;
    {DATA_ADDR, WDATA, PC_ADDR} <= ~{a[7:0], d, a};
    #1;
  endtask
  task unlock_write(input logic [7:0] a, d);
    req(3'h0, 1'b1, 1'b1, 1'b0, 16'h00c7, 8'haa);
    req(3'h0, 1'b1, 1'b1, 1'b0, 16'h00c7, 8'h55);
    req(3'h0, 1'b1, 1'b1, 1'b0, {8'h00, a}, d);
  endtask
endmodule // cpu_model

// *** sim/mem_decode_test.sv ***
// Self-checking bench for the memory-map decoder
`timescale 1ns/1ps
module mem_decode_test;
  localparam APP = 18432;
  logic        CLK_SYS = 1'b0, NRST = 1'b0, BOOT_SELECT = 1'b0;
  logic [7:0]  BOOT_SIZE_CONFIG = 8'hff;
  logic [15:0] exp_boot;
  int          errors = 0, checks_done = 0;
  wire         FETCH_REQ, CODE_READ, IRQ_TAKE, DATA_REQ, DATA_WRITE, DIRECT_MODE, BIT_MODE, REG_OPERAND;
  wire         PUSH, POP, EXT_REQ, EXT_USE_POINTER, CODE_SEL_BOOT, CODE_VALID, CODE_FAULT, RAM_EN, RAM_WE;
  wire         SFR_EN, SFR_WE, SFR_PAGE, SFR_BIT_FAULT, AUX_EN, AUX_FAULT;
  wire [3:0]   IRQ_NUM;
  wire [2:0]   REG_NUM, RAM_BIT, SFR_BIT;
  wire [7:0]   DATA_ADDR, WDATA, RAM_ADDR, SFR_ADDR, STACK_POINTER, PAGE_SELECT;
  wire [9:0]   AUX_ADDR;
  wire [15:0]  PC_ADDR, DATA_POINTER, CODE_ADDR, BOOT_BYTES, APP_LIMIT;
  always #5 CLK_SYS = ~CLK_SYS;
  mem_decode #(.APP_BYTES(APP)) i_mem_decode (.*);
  cpu_model i_cpu_model (.*);
  task chk(input logic [19:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask
  task rst(input logic [7:0] cfg);
    @(posedge CLK_SYS);
    NRST <= 1'b0;
    BOOT_SIZE_CONFIG <= cfg;
    repeat (16) @(posedge CLK_SYS);
    NRST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    #1;
  endtask
  task test_done;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #100000;
    errors++;
    test_done;
  end
  initial
  begin
    for (int c = 7; c >= 3; c--)
    begin
      rst({5'h1f, 3'(c)});
      exp_boot = c > 3 ? 16'((7 - c) * 1024) : 16'h1000;
      chk(BOOT_BYTES, exp_boot);
      chk(APP_LIMIT, 16'(APP) - exp_boot);
    end
    @(posedge CLK_SYS) BOOT_SIZE_CONFIG <= 8'hff;
    chk({STACK_POINTER, PAGE_SELECT}, 20'h00700);
    i_cpu_model.req(3'h3, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk({CODE_VALID, CODE_FAULT, CODE_ADDR}, 20'h20000);
    i_cpu_model.req(3'h4, 1'b0, 1'b0, 1'b0, 16'h37ff, 8'h00);
    chk({CODE_VALID, CODE_FAULT, CODE_ADDR}, 20'h237ff);
    i_cpu_model.req(3'h3, 1'b0, 1'b0, 1'b0, 16'h3800, 8'h00);
    chk({CODE_FAULT, BOOT_BYTES}, 20'h11000);
    for (int b = 0; b < 2; b++)
    begin
      @(posedge CLK_SYS) BOOT_SELECT <= b[0];
      for (int n = 0; n < 4; n++)
      begin
        i_cpu_model.req(3'h5, 1'b0, 1'b0, 1'b0, 16'(n), 8'h00);
        chk({CODE_SEL_BOOT, CODE_ADDR}, {b[0], 16'(3 + n * 8)});
      end
    end
    i_cpu_model.req(3'h3, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk({CODE_SEL_BOOT, CODE_ADDR}, 20'h10000);
    i_cpu_model.req(3'h3, 1'b0, 1'b0, 1'b0, 16'h1000, 8'h00);
    chk({CODE_SEL_BOOT, CODE_FAULT}, 20'h3);
    i_cpu_model.req(3'h0, 1'b0, 1'b1, 1'b0, 16'h0085, 8'h00);
    chk({SFR_EN, RAM_EN, SFR_ADDR}, {2'b10, 8'h85});
    i_cpu_model.req(3'h0, 1'b1, 1'b0, 1'b0, 16'h0085, 8'h00);
    chk({SFR_EN, RAM_EN, RAM_WE, RAM_ADDR}, {3'b011, 8'h85});
    i_cpu_model.req(3'h0, 1'b0, 1'b1, 1'b0, 16'h0030, 8'h00);
    chk({SFR_EN, RAM_EN, RAM_ADDR}, {2'b01, 8'h30});
    i_cpu_model.req(3'h0, 1'b0, 1'b1, 1'b1, 16'h000f, 8'h00);
    chk({RAM_EN, RAM_ADDR, RAM_BIT}, {1'b1, 8'h21, 3'h7});
    i_cpu_model.req(3'h0, 1'b0, 1'b1, 1'b1, 16'h008a, 8'h00);
    chk({SFR_EN, SFR_ADDR, SFR_BIT}, {1'b1, 8'h88, 3'h2});
    i_cpu_model.req(3'h0, 1'b1, 1'b1, 1'b0, 16'h00d0, 8'h18);
    chk({SFR_EN, SFR_WE, SFR_ADDR}, {2'b11, 8'hd0});
    i_cpu_model.req(3'h0, 1'b0, 1'b0, 1'b0, 16'h8500, 8'h00);
    chk(RAM_ADDR, 20'h1d);
    i_cpu_model.req(3'h1, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk({AUX_EN, RAM_WE, RAM_ADDR, STACK_POINTER}, {2'b01, 16'h0808});
    i_cpu_model.req(3'h2, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk({RAM_WE, RAM_ADDR, STACK_POINTER}, {1'b0, 16'h0807});
    i_cpu_model.req(3'h0, 1'b1, 1'b1, 1'b0, 16'h0081, 8'hf0);
    i_cpu_model.req(3'h1, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h00);
    chk({RAM_ADDR, STACK_POINTER}, 20'hf1f1);
    i_cpu_model.req(3'h6, 1'b0, 1'b0, 1'b0, 16'h02ff, 8'h00);
    chk({AUX_EN, AUX_FAULT, AUX_ADDR}, {2'b10, 10'h2ff});
    i_cpu_model.req(3'h6, 1'b0, 1'b0, 1'b0, 16'h0300, 8'h00);
    chk({AUX_EN, AUX_FAULT}, 20'h1);
    i_cpu_model.req(3'h7, 1'b0, 1'b0, 1'b0, 16'h0000, 8'h23);
    chk({AUX_EN, AUX_ADDR}, {1'b1, 10'h023});
    i_cpu_model.req(3'h0, 1'b1, 1'b1, 1'b0, 16'h0091, 8'h01);
    chk({SFR_PAGE, PAGE_SELECT}, 20'h0);
    i_cpu_model.unlock_write(8'h91, 8'h01);
    i_cpu_model.req(3'h0, 1'b0, 1'b1, 1'b0, 16'h0088, 8'h00);
    chk({SFR_PAGE, PAGE_SELECT}, 20'h101);
    test_done;
  end
endmodule // mem_decode_test
